// file: design/holding_bank.v
// eight-entry byte holding register bank
`timescale 1ns/100ps
`include "table_write_consts.vh"

module holding_bank #(
    parameter DEPTH  = 8,
    parameter SEL_W  = `TW_SEL_W
) (
    // clock and reset
    input  wire                 sys_clk,
    input  wire                 rst_n,
    // write port
    input  wire                 wr_en,
    input  wire [SEL_W-1:0]     wr_sel,
    input  wire [7:0]           wr_data,
    // flattened contents for the programming logic
    output wire [DEPTH*8-1:0]   hold_flat
);

    reg [7:0] hold_r [0:DEPTH-1];
    integer   i;
    genvar    g;

    // bytes stay until overwritten so a later program cycle can use them
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            for (i = 0; i < DEPTH; i = i + 1) begin
                hold_r[i] <= `TW_HOLD_RST;
            end
        end else if (wr_en) begin
            hold_r[wr_sel] <= wr_data;
        end
    end

    generate
        for (g = 0; g < DEPTH; g = g + 1) begin : flat
            assign hold_flat[g*8 +: 8] = hold_r[g];
        end
    endgenerate

endmodule // holding_bank

// file: design/table_write_consts.vh
// constants for the table-write instruction unit
`ifndef TABLE_WRITE_CONSTS_VH
`define TABLE_WRITE_CONSTS_VH

`define TW_OPC_HI_W        14
`define TW_OPC_HI_VAL      14'h0003
`define TW_MODE_W          2
`define TW_MODE_NONE       2'h0
`define TW_MODE_POSTINC    2'h1
`define TW_MODE_POSTDEC    2'h2
`define TW_MODE_PREINC     2'h3
`define TW_PTR_W           21
`define TW_PTR_RST         21'h000000
`define TW_PTR_ONE         21'h000001
`define TW_SEL_W           3
`define TW_BYTE_BIT        0
`define TW_HOLD_RST        8'hff
`define TW_LATCH_RST       8'h00

`endif

// file: design/table_write_instruction_unit.v
// table-write instruction decode and execute unit
//
// Behaviour
// (RL1) opcode is twelve zeros, then 11, then 2-bit mode
// (RL2) mode 0 writes latch to holding register, pointer unchanged
// (RL3) mode 1 writes at current pointer, then pointer plus one
// (RL4) mode 2 writes at current pointer, then pointer minus one
// (RL5) mode 3 increments pointer first, writes at new pointer
// (RL6) three low pointer bits select one of eight holding registers
// (RL7) pointer is 21 bits, byte address, two megabyte range
// (RL8) pointer bit 0 selects low (0) or high (1) byte of word
// (RL9) holding bytes stay available for later programming
// (RL10) one word, two cycles, write in second cycle, no flags changed
`timescale 1ns/100ps
`include "table_write_consts.vh"

module table_write_instruction_unit #(
    parameter PTR_W  = `TW_PTR_W,
    parameter DEPTH  = 8
) (
    // clock and reset
    input  wire                 sys_clk,
    input  wire                 rst_n,
    // instruction from the sequencer
    input  wire                 instr_valid,
    input  wire [15:0]          instr_word,
    // table latch and pointer load from the core
    input  wire [7:0]           table_latch,
    input  wire                 ptr_load,
    input  wire [PTR_W-1:0]     ptr_load_val,
    // state back to the core
    output reg  [PTR_W-1:0]     table_pointer_r,
    output reg                  busy_r,
    output reg                  done_r,
    output reg                  word_hi_byte_r,
    // holding contents for the programming logic
    output wire [DEPTH*8-1:0]   hold_flat
);

    // ------------------------------------------------------------
    // state encoding
    // ------------------------------------------------------------
    // one-hot, so an illegal code falls back to idle through the default arm
    localparam [1:0] ST_IDLE  = 2'b01;
    localparam [1:0] ST_EXEC  = 2'b10;

    // ------------------------------------------------------------
    // internal signals
    // ------------------------------------------------------------
    reg [1:0]               state_r;
    reg [1:0]               state_nxt;
    reg [`TW_MODE_W-1:0]    mode_r;
    reg [`TW_MODE_W-1:0]    mode_nxt;
    reg [PTR_W-1:0]         ptr_nxt;
    reg                     wr_en;
    reg [`TW_SEL_W-1:0]     wr_sel;

    wire [`TW_MODE_W-1:0]   dec_mode;
    wire                    is_tblwr;
    wire                    in_idle;
    wire                    take;
    wire [PTR_W-1:0]        ptr_inc;
    wire [PTR_W-1:0]        ptr_dec;

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    // pointer step; wraps within the pointer width like the byte address space
    function [PTR_W-1:0] ptr_add;
        input [PTR_W-1:0] p;
        input             dec;
        begin
            if (dec)
                ptr_add = p - `TW_PTR_ONE;
            else
                ptr_add = p + `TW_PTR_ONE;
        end
    endfunction

    // low pointer bits pick the holding register
    function [`TW_SEL_W-1:0] hold_index;
        input [PTR_W-1:0] p;
        begin
            hold_index = p[`TW_SEL_W-1:0];
        end
    endfunction

    // only the table-write group is decoded; every other word is left to the core
    function opc_match;
        input [15:0] w;
        begin
            opc_match = (w[15:`TW_MODE_W] == `TW_OPC_HI_VAL);
        end
    endfunction

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    assign dec_mode = instr_word[`TW_MODE_W-1:0]; // RL1
    assign is_tblwr = instr_valid && opc_match(instr_word); // RL1
    assign in_idle  = (state_r == ST_IDLE);
    // a word that arrives while a write executes is dropped without notice
    assign take     = in_idle && is_tblwr; // RL10
    assign ptr_inc  = ptr_add(table_pointer_r, 1'b0);
    assign ptr_dec  = ptr_add(table_pointer_r, 1'b1);

    // ------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------
    // the write always lands in the second cycle, so the core can rely on a fixed length
    always @* begin
        state_nxt = state_r;
        mode_nxt  = mode_r;
        case (state_r)
            ST_IDLE: begin
                if (take) begin
                    state_nxt = ST_EXEC; // RL10
                    mode_nxt  = dec_mode; // RL1
                end
            end
            ST_EXEC: begin
                state_nxt = ST_IDLE; // RL10
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // table pointer
    // ------------------------------------------------------------
    // a load in the taking cycle is honoured; the execute cycle then works on the loaded value
    always @* begin
        ptr_nxt = table_pointer_r;
        case (state_r)
            ST_IDLE: begin
                if (ptr_load)
                    ptr_nxt = ptr_load_val;
            end
            ST_EXEC: begin
                case (mode_r)
                    `TW_MODE_NONE: begin
                        ptr_nxt = table_pointer_r; // RL2
                    end
                    `TW_MODE_POSTINC: begin
                        ptr_nxt = ptr_inc; // RL3
                    end
                    `TW_MODE_POSTDEC: begin
                        ptr_nxt = ptr_dec; // RL4
                    end
                    default: begin
                        ptr_nxt = ptr_inc; // RL5
                    end
                endcase
            end
            default: begin
                ptr_nxt = table_pointer_r;
            end
        endcase
    end

    // ------------------------------------------------------------
    // holding register write port
    // ------------------------------------------------------------
    // pre-increment writes at the stepped pointer, every other mode at the current one
    always @* begin
        wr_en  = 1'b0;
        wr_sel = hold_index(table_pointer_r); // RL6
        case (state_r)
            ST_EXEC: begin
                wr_en = 1'b1; // RL10
                if (mode_r == `TW_MODE_PREINC)
                    wr_sel = hold_index(ptr_inc); // RL5
                else
                    wr_sel = hold_index(table_pointer_r); // RL3 RL4
            end
            default: begin
                wr_en = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // state and mode registers
    // ------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            mode_r  <= `TW_MODE_NONE;
        end else begin
            state_r <= state_nxt;
            mode_r  <= mode_nxt; // RL1
        end
    end

    // ------------------------------------------------------------
    // pointer and byte-select registers
    // ------------------------------------------------------------
    // the byte flag is taken from the next pointer so it never lags the pointer
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            table_pointer_r <= `TW_PTR_RST; // RL7
            word_hi_byte_r  <= 1'b0;
        end else begin
            table_pointer_r <= ptr_nxt; // RL7
            word_hi_byte_r  <= ptr_nxt[`TW_BYTE_BIT]; // RL8
        end
    end

    // ------------------------------------------------------------
    // status registers
    // ------------------------------------------------------------
    // no arithmetic flags live here; the core sees only busy and done
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            busy_r <= (state_nxt == ST_EXEC); // RL10
            done_r <= wr_en; // RL10
        end
    end

    // ------------------------------------------------------------
    // holding registers
    // ------------------------------------------------------------
    holding_bank #(
        .DEPTH (DEPTH),
        .SEL_W (`TW_SEL_W)
    ) u_bank (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .wr_en     (wr_en),
        .wr_sel    (wr_sel),
        .wr_data   (table_latch),
        .hold_flat (hold_flat)
    ); // RL9

endmodule // table_write_instruction_unit

// file: verification/seq_model.sv
// behavioural instruction sequencer for the table-write unit
`timescale 1ns/100ps
module seq_model (
    // clock
    input wire        sys_clk,
    // instruction and pointer side
    output reg        instr_valid,
    output reg [15:0] instr_word,
    output reg [7:0]  table_latch,
    output reg        ptr_load,
    output reg [20:0] ptr_load_val
);
    initial begin
        instr_valid = 1'b0;
        instr_word = 16'hffff;
        table_latch = 8'h00;
        ptr_load = 1'b0;
        ptr_load_val = 21'h000000;
    end
    // released lines show the inverse so stale values never pass
    task drop;
        begin
            @(negedge sys_clk);
            instr_valid = 1'b0;
            instr_word = ~instr_word;
            ptr_load = 1'b0;
            ptr_load_val = ~ptr_load_val;
        end
    endtask
    task load(input [20:0] v);
        begin
            @(negedge sys_clk);
            ptr_load = 1'b1;
            ptr_load_val = v;
            drop;
        end
    endtask
    // junk keeps requests up in the execute cycle; the latch is set with the word, one edge before that
    task issue(input [15:0] w, input [7:0] d, input junk);
        begin
            @(negedge sys_clk);
            instr_valid = 1'b1;
            instr_word = w;
            table_latch = d;
            @(negedge sys_clk);
            instr_valid = junk;
            ptr_load = junk;
            if (!junk) instr_word = ~w;
        end
    endtask
endmodule // seq_model

// file: verification/table_write_instruction_unit_props.sv
// checker for the table-write unit
`timescale 1ns/100ps
module tw_props #(parameter PTR_W = 21, parameter DEPTH = 8) (
    // clock and reset
    input wire               sys_clk,
    input wire               rst_n,
    // core side
    input wire               instr_valid,
    input wire [15:0]        instr_word,
    input wire [7:0]         table_latch,
    // results
    input wire [PTR_W-1:0]   table_pointer_r,
    input wire               busy_r,
    input wire               done_r,
    input wire               word_hi_byte_r,
    input wire [DEPTH*8-1:0] hold_flat
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    wire      take = !busy_r && instr_valid && instr_word[15:2] == 14'h0003;
    reg [1:0] mode_r;
    always @(posedge sys_clk) if (take) mode_r <= instr_word[1:0];
    take_busy_a: assert property (take |=> busy_r && !done_r) else $error("no busy");
    busy_done_a: assert property (busy_r |=> !busy_r && done_r) else $error("no done");
    busy_src_a: assert property (busy_r |-> $past(take)) else $error("stray busy");
    ptr_keep_a: assert property (take && instr_word[1:0] == 2'h0 |=> ##1
        table_pointer_r == $past(table_pointer_r)) else $error("ptr moved");
    ptr_inc_a: assert property (take && instr_word[0] |=> ##1
        table_pointer_r == $past(table_pointer_r) + 1'b1) else $error("bad inc");
    ptr_dec_a: assert property (take && instr_word[1:0] == 2'h2 |=> ##1
        table_pointer_r == $past(table_pointer_r) - 1'b1) else $error("bad dec");
    word_hi_a: assert property (word_hi_byte_r == table_pointer_r[0]) else $error("bad hi");
    hold_wr_a: assert property (done_r |-> hold_flat[8*(mode_r == 2'h3 ?
        table_pointer_r[2:0] : $past(table_pointer_r[2:0])) +: 8] == $past(table_latch)) else $error("bad write");
    hold_keep_a: assert property (!busy_r |=> $stable(hold_flat)) else $error("hold lost");
    cover property (take && instr_word[1:0] == 2'h3);
    cover property (done_r && take);
    cover property (busy_r && instr_valid);
endmodule // tw_props
bind table_write_instruction_unit tw_props #(.PTR_W(PTR_W), .DEPTH(DEPTH)) i_tw_props (.*);

// file: verification/table_write_instruction_unit_tb_top.sv
// self-checking bench for the table-write unit
`timescale 1ns/100ps
`define CHK(n, e, a) begin compares += 1; if ((a) !== (e)) begin n_fail += 1; $display("wrong value %s exp %h got %h", n, e, a); end end
module table_write_instruction_unit_tb_top;
    reg         sys_clk = 1'b0;
    reg         rst_n = 1'b0;
    wire        instr_valid, ptr_load, busy_r, done_r, word_hi_byte_r;
    wire [15:0] instr_word;
    wire [7:0]  table_latch;
    wire [20:0] ptr_load_val, table_pointer_r;
    wire [63:0] hold_flat;
    integer     n_fail = 0, compares = 0, i;
    reg  [56:0] rows [0:4];
    reg  [56:0] r;
    seq_model i_seq_model (.*);
    table_write_instruction_unit i_table_write_instruction_unit (.*);
    initial forever #20 sys_clk = ~sys_clk;
    task end_of_test;
        begin
            $display("comparisons %0d mismatches %0d", compares, n_fail);
            if (n_fail == 0 && compares > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    task check(input [20:0] p, input [2:0] s, input [7:0] v, input d);
        begin
            `CHK("pointer", p, table_pointer_r)
            `CHK("hold byte", v, hold_flat[8*s +: 8])
            `CHK("done", d, done_r)
            `CHK("high byte", p[0], word_hi_byte_r)
            `CHK("busy", 1'b0, busy_r)
        end
    endtask
    initial begin
        rows[0] = {16'h000d, 8'h55, 21'h00a357, 3'h6, 8'h55, 1'b1};
        rows[1] = {16'h000f, 8'h34, 21'h00a358, 3'h0, 8'h34, 1'b1};
        rows[2] = {16'h000e, 8'h12, 21'h00a357, 3'h0, 8'h12, 1'b1};
        rows[3] = {16'h000c, 8'h9a, 21'h00a357, 3'h7, 8'h9a, 1'b1};
        rows[4] = {16'h400d, 8'h77, 21'h00a357, 3'h7, 8'h9a, 1'b0};
        repeat (4) @(negedge sys_clk);
        rst_n = 1'b1;
        check(21'h000000, 3'h5, 8'hff, 1'b0);
        `CHK("hold reset", {8{8'hff}}, hold_flat)
        $display("test reset done");
        i_seq_model.load(21'h00a356);
        for (i = 0; i < 5; i = i + 1) begin
            r = rows[i];
            i_seq_model.issue(r[56:41], r[40:33], 1'b0);
            @(negedge sys_clk);
            check(r[32:12], r[11:9], r[8:1], r[0]);
        end
        $display("test rows done");
        // wrap at the top of the range, then a back-to-back pre-increment
        i_seq_model.load(21'h1fffff);
        i_seq_model.issue(16'h000d, 8'hc3, 1'b0);
        `CHK("busy high", 1'b1, busy_r)
        i_seq_model.issue(16'h000f, 8'h3c, 1'b0);
        @(negedge sys_clk);
        check(21'h000001, 3'h1, 8'h3c, 1'b1);
        `CHK("wrap byte", 8'hc3, hold_flat[63:56])
        $display("test wrap done");
        i_seq_model.issue(16'h000c, 8'h5a, 1'b1);
        i_seq_model.drop;
        check(21'h000001, 3'h1, 8'h5a, 1'b1);
        @(negedge sys_clk);
        `CHK("refused", 1'b0, done_r)
        $display("test refuse done");
        // reset in the execute cycle drops the write and restores every value
        i_seq_model.issue(16'h000d, 8'h11, 1'b0);
        rst_n = 1'b0;
        @(negedge sys_clk);
        rst_n = 1'b1;
        check(21'h000000, 3'h1, 8'hff, 1'b0);
        `CHK("hold after reset", {8{8'hff}}, hold_flat)
        $display("test reset in flight done");
        end_of_test;
    end
    initial begin
        repeat (500) @(posedge sys_clk);
        n_fail += 1;
        end_of_test;
    end
endmodule // table_write_instruction_unit_tb_top
